// [dcp_host_model.sv]
/*
  behavioural i2c host for the dac command port: makes scl and sda frames.
  assumes the device pulls sda low through its oe output and both lines pull up.
*/
`timescale 1ns/100ps
module dcp_host_model
  import dcp_pkg::*;
#(
  parameter int HALF = 10  // 400 ns bit period, inside the 3400 khz hs rate only
)
(
  input wire logic core_clk,
  input wire logic dev_sda_oe,
  output logic scl = 1'b1,  // only the host makes the clock; stands high when idle
  output logic sda
);
  logic pull_low = 1'b0;

  // open drain: either party pulls low, otherwise the pull-up wins
  assign sda = (pull_low || dev_sda_oe) ? 1'b0 : 1'b1;

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // sda moves while scl is high; start and stop share this shape
  task automatic cond(input logic first, input logic last);
    wt(HALF / 2);
    pull_low <= first;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF);
    pull_low <= last;
    wt(HALF);
  endtask

  task automatic start();
    cond(1'b0, 1'b1);
    scl <= 1'b0;
  endtask

  task automatic stop();
    cond(1'b1, 1'b0);
  endtask

  // data moves mid low phase and holds over the whole high phase
  task automatic put_bit(input logic b);
    wt(HALF / 2);
    pull_low <= !b;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF);
    scl <= 1'b0;
  endtask

  // released line is read mid high phase, once the device has settled
  task automatic get_bit(output logic b);
    wt(HALF / 2);
    pull_low <= 1'b0;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF / 2);
    b = sda;
    wt(HALF / 2);
    scl <= 1'b0;
  endtask

  // msb first; the ninth clock carries the acknowledge
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask

  task automatic byte_rd(input logic host_ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(!host_ack);
  endtask
endmodule // dcp_host_model

// [dcp_mem.sv]
/*
  location memory of the dac command port: one write port, one read port
  with registered read data.
  assumes writer and reader share core_clk; reset clears every entry.
*/
`timescale 1ns/100ps
module dcp_mem
  import dcp_pkg::*;
#(
  parameter int DEPTH = NUM_LOC,
  parameter int WIDTH = WORD_W,
  parameter int AW = ADDR_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] store [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1)
    $error("dcp_mem depth does not fit address width");

  // synchronous clear keeps reads defined before any write
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        store[i] <= '0;
    end
    else if (clk_en && we)
      store[waddr] <= wdata;
  end

  // registered read port
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (clk_en)
      rdata <= store[raddr];
  end
endmodule // dcp_mem

// [dcp_pkg.sv]
/*
  constants, field layout and state type shared by the dac command port
  and its location memory. assumes a 50 mhz core clock.
*/
package dcp_pkg;
  // core clock and spike filter timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int HS_SPIKE_NS = 10;
  localparam int FS_SPIKE_NS = 50;
  localparam int HS_FILT_CYC = (HS_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FS_FILT_CYC = (FS_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus bit rates served
  localparam int STD_RATE_KHZ = 100;
  localparam int FAST_RATE_KHZ = 400;
  localparam int HS_RATE_KHZ = 3400;
  // memory and word layout
  localparam int ADDR_W = 5;
  localparam int WORD_W = 16;
  localparam int NUM_LOC = 32;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [4:0] VOL_LAST = 5'h0b;
  localparam logic [4:0] NV_FIRST = 5'h10;
  // command byte fields
  localparam int CMD_ADDR_LSB = 3;
  localparam int CMD_CODE_LSB = 1;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h3;
  // address byte, general call code and word reset values
  localparam logic [4:0] DEF_UPPER_ADDR = 5'h18;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] GC_RESET_CODE = 8'h06;
  localparam logic [7:0] GC_WAKE_CODE = 8'h0a;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_cmd,
    st_wdata,
    st_gc,
    st_rdata,
    st_ignore
  } dcp_state_t;
endpackage

// [dcp_port.sv]
/*
  i2c client and command decoder of a multi channel dac.
  assumes scl/sda, address pins, latch pins and the programming voltage
  sense come from pins; lock bits and nv address bits from core logic.
*/
`timescale 1ns/100ps
module dcp_port
  import dcp_pkg::*;
#(
  parameter int NCH = 8,
  parameter bit NONVOLATILE = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_hi,
  input wire logic addr_select_pin_lo,
  input wire logic [4:0] upper_client_addr_bits,
  input wire logic prog_voltage_present,
  input wire logic [NUM_LOC-1:0] location_write_lock_bits,
  input wire logic [NCH-1:0] channel_output_latch_pin_n,
  output logic [NCH*WORD_W-1:0] dac_out,
  output logic hs_mode,
  output logic [ADDR_W-1:0] mem_addr_ptr,
  output logic wake_pulse,
  output logic gc_reset_pulse
);
  localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;
  localparam logic [2:0] HS_NEED = 3'(HS_FILT_CYC);
  localparam logic [2:0] FS_NEED = 3'(FS_FILT_CYC);
  localparam int TAPS = FS_FILT_CYC + 1;

  if (NCH < 1 || NCH != (1 << CH_W) || NCH > int'(VOL_LAST) + 1)
    $error("dcp_port channel count must be a power of two within volatile space");
  if (FS_FILT_CYC > 6 || HS_FILT_CYC < 1)
    $error("dcp_port spike filter counts out of range");

  // two-flop synchronisers for every pin input
  logic scl_m, scl_s, sda_m, sda_s, pin_hi_m, pin_hi_s, pin_lo_m, pin_lo_s, hv_m, hv_s;
  logic [NCH-1:0] lat_m, lat_s;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {scl_m, scl_s, sda_m, sda_s} <= 4'hf;
      {pin_hi_m, pin_hi_s, pin_lo_m, pin_lo_s, hv_m, hv_s} <= 6'h00;
      lat_m <= '1;
      lat_s <= '1;
    end
    else if (clk_en)
    begin
      {scl_m, scl_s, sda_m, sda_s} <= {scl_in, scl_m, sda_in, sda_m};
      {pin_hi_m, pin_hi_s} <= {addr_select_pin_hi, pin_hi_m};
      {pin_lo_m, pin_lo_s} <= {addr_select_pin_lo, pin_lo_m};
      {hv_m, hv_s} <= {prog_voltage_present, hv_m};
      lat_m <= channel_output_latch_pin_n;
      lat_s <= lat_m;
    end
  end

  // scl spike filter; shorter window in hs mode
  logic scl_f, scl_fq;
  logic [2:0] filt_cnt;
  logic [2:0] need_cyc;
  assign need_cyc = hs_mode ? HS_NEED : FS_NEED;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scl_f <= 1'b1;
      filt_cnt <= 3'h0;
    end
    else if (clk_en)
    begin
      if (scl_s == scl_f)
        filt_cnt <= 3'h0;
      else if (filt_cnt + 3'h1 >= need_cyc)
      begin
        scl_f <= scl_s;
        filt_cnt <= 3'h0;
      end
      else
        filt_cnt <= filt_cnt + 3'h1;
    end
  end

  // sda delayed one cycle past the filtered scl, so that a data change
  // right after a falling scl edge is never mistaken for start or stop
  logic [TAPS-1:0] sda_tap;
  logic sda_d, sda_dq;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sda_tap <= '1;
      scl_fq <= 1'b1;
      sda_dq <= 1'b1;
    end
    else if (clk_en)
    begin
      sda_tap <= {sda_tap[TAPS-2:0], sda_s};
      scl_fq <= scl_f;
      sda_dq <= sda_d;
    end
  end
  assign sda_d = hs_mode ? sda_tap[HS_FILT_CYC] : sda_tap[FS_FILT_CYC];

  // bus events
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_f && !scl_fq;
  assign scl_fall = !scl_f && scl_fq;
  assign start_ev = scl_f && scl_fq && sda_dq && !sda_d;
  assign stop_ev = scl_f && scl_fq && !sda_dq && sda_d;

  dcp_state_t state, pend;
  logic [3:0] bitcnt;
  logic [7:0] shreg, rx_byte, data_hi;
  logic [15:0] tx, rd_word, mem_rdata;
  logic ack_phase, ack_go, byte_sel, host_ack, receiving, last_rx;
  logic nv_pending, nv_arm, mem_we;
  logic [ADDR_W-1:0] nv_addr, mem_waddr, cmd_addr;
  logic [15:0] nv_data, mem_wdata;
  logic [1:0] cmd_code;
  logic [6:0] client_addr;
  logic [4:0] upper_sel;
  logic [15:0] shadow [NCH];
  logic [15:0] out_reg [NCH];

  assign rx_byte = {shreg[6:0], sda_d};
  assign cmd_addr = rx_byte[CMD_ADDR_LSB +: ADDR_W];
  assign cmd_code = rx_byte[CMD_CODE_LSB +: 2];
  assign receiving = state inside {st_addr, st_cmd, st_wdata, st_gc};
  assign last_rx = receiving && scl_rise && !ack_phase && bitcnt == 4'h7;
  // pins left open are pulled low outside, reading as zero
  assign upper_sel = NONVOLATILE ? upper_client_addr_bits : DEF_UPPER_ADDR;
  assign client_addr = {upper_sel, pin_hi_s, pin_lo_s};
  assign rd_word = (mem_addr_ptr < ADDR_W'(NCH)) ? shadow[mem_addr_ptr[CH_W-1:0]] : mem_rdata;

  // byte decode, evaluated on the eighth rising scl edge
  logic dec_ack, set_hs, set_ptr, commit, gc_rst, gc_wake;
  dcp_state_t dec_next;
  always_comb
  begin
    dec_ack = 1'b0;
    dec_next = st_ignore;
    set_hs = 1'b0;
    set_ptr = 1'b0;
    commit = 1'b0;
    gc_rst = 1'b0;
    gc_wake = 1'b0;
    case (state)
      st_addr:
      begin
        // first byte after any start is the address byte
        if (rx_byte == GC_ADDR_BYTE)
        begin
          dec_ack = 1'b1;
          dec_next = st_gc;
        end
        else if (rx_byte[7:3] == HS_CODE_TOP)
        begin
          set_hs = 1'b1;
          dec_next = st_idle;
        end
        else if (rx_byte[7:1] == client_addr)
        begin
          dec_ack = 1'b1;
          dec_next = rx_byte[0] ? st_rdata : st_cmd;
        end
      end
      st_cmd:
      begin
        // bad code, hole in the map or pending nv write: nack and drop out
        if (!nv_pending && (cmd_addr <= VOL_LAST || cmd_addr >= NV_FIRST)
            && (cmd_code == CMD_WRITE || cmd_code == CMD_READ))
        begin
          dec_ack = 1'b1;
          set_ptr = 1'b1;
          dec_next = (cmd_code == CMD_WRITE) ? st_wdata : st_cmd;
        end
      end
      st_wdata:
      begin
        dec_ack = 1'b1;
        commit = byte_sel;
        // after a word the next command byte follows directly
        dec_next = byte_sel ? st_cmd : st_wdata;
      end
      st_gc:
      begin
        if (rx_byte == GC_RESET_CODE)
        begin
          dec_ack = 1'b1;
          gc_rst = 1'b1;
        end
        else if (rx_byte == GC_WAKE_CODE)
        begin
          dec_ack = 1'b1;
          gc_wake = 1'b1;
        end
      end
      default:
        dec_ack = 1'b0;
    endcase
  end

  // bit engine; sda is open drain and scl is never driven
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= st_idle;
      pend <= st_idle;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= WORD_RESET;
      {ack_phase, ack_go, byte_sel, host_ack, sda_oe} <= 5'h00;
    end
    else if (clk_en)
    begin
      if (start_ev || stop_ev)
      begin
        // abort anything in flight; a half word is simply never committed
        state <= start_ev ? st_addr : st_idle;
        bitcnt <= 4'h0;
        {ack_phase, byte_sel, sda_oe} <= 3'h0;
      end
      else if (state == st_rdata)
      begin
        if (scl_rise && !ack_phase && bitcnt < 4'h8)
          bitcnt <= bitcnt + 4'h1;
        else if (scl_rise && ack_phase)
          host_ack <= !sda_d;
        else if (scl_fall && !ack_phase)
        begin
          if (bitcnt == 4'h8)
          begin
            sda_oe <= 1'b0;
            ack_phase <= 1'b1;
          end
          else
          begin
            sda_oe <= !tx[15];
            tx <= {tx[14:0], 1'b0};
          end
        end
        else if (scl_fall && ack_phase)
        begin
          ack_phase <= 1'b0;
          bitcnt <= 4'h0;
          if (!host_ack)
          begin
            state <= st_ignore;
            sda_oe <= 1'b0;
          end
          else if (byte_sel)
          begin
            // continuous read repeats the same location
            sda_oe <= !rd_word[15];
            tx <= {rd_word[14:0], 1'b0};
            byte_sel <= 1'b0;
          end
          else
          begin
            sda_oe <= !tx[15];
            tx <= {tx[14:0], 1'b0};
            byte_sel <= 1'b1;
          end
        end
      end
      else if (receiving)
      begin
        if (scl_rise && !ack_phase && bitcnt < 4'h8)
        begin
          shreg <= rx_byte;
          bitcnt <= bitcnt + 4'h1;
          if (bitcnt == 4'h7)
          begin
            ack_go <= dec_ack;
            pend <= dec_next;
            if (state == st_wdata)
              byte_sel <= !byte_sel;
          end
        end
        else if (scl_fall && !ack_phase && bitcnt == 4'h8)
        begin
          ack_phase <= 1'b1;
          sda_oe <= ack_go;
        end
        else if (scl_fall && ack_phase)
        begin
          ack_phase <= 1'b0;
          bitcnt <= 4'h0;
          state <= pend;
          sda_oe <= (pend == st_rdata) ? !rd_word[15] : 1'b0;
          tx <= {rd_word[14:0], 1'b0};
        end
      end
    end
  end
  // open drain pad: the driven level is always low, sda_oe decides when
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sda_out <= 1'b0;
    else if (clk_en)
      sda_out <= 1'b0;
  end

  // pointer only moves on a taken command byte
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mem_addr_ptr <= PTR_RESET;
    else if (clk_en && last_rx && set_ptr)
      mem_addr_ptr <= cmd_addr;
  end

  // hs mode holds across restart, drops at stop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      hs_mode <= 1'b0;
    else if (clk_en && stop_ev)
      hs_mode <= 1'b0;
    else if (clk_en && last_rx && set_hs)
      hs_mode <= 1'b1;
  end

  // general call pulses
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      {wake_pulse, gc_reset_pulse} <= 2'h0;
    else if (clk_en)
      {wake_pulse, gc_reset_pulse} <= {last_rx && gc_wake, last_rx && gc_rst};
  end

  // word commit on the final data bit edge; 8-bit parts share the frame
  logic vol_ok;
  assign vol_ok = mem_addr_ptr <= VOL_LAST && !location_write_lock_bits[mem_addr_ptr];
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      data_hi <= 8'h00;
      {nv_pending, nv_arm, mem_we} <= 3'h0;
      nv_addr <= PTR_RESET;
      mem_waddr <= PTR_RESET;
      nv_data <= WORD_RESET;
      mem_wdata <= WORD_RESET;
    end
    else if (clk_en)
    begin
      mem_we <= 1'b0;
      if (last_rx && state == st_wdata && !byte_sel)
        data_hi <= rx_byte;
      if (last_rx && commit && vol_ok && mem_addr_ptr >= ADDR_W'(NCH))
      begin
        mem_we <= 1'b1;
        mem_waddr <= mem_addr_ptr;
        mem_wdata <= {data_hi, rx_byte};
      end
      else if (last_rx && commit && mem_addr_ptr >= NV_FIRST)
      begin
        // acked either way; without hv the location stays as it is
        nv_pending <= 1'b1;
        nv_arm <= hv_s;
        nv_addr <= mem_addr_ptr;
        nv_data <= {data_hi, rx_byte};
      end
      else if (last_rx && nv_pending)
        // any byte after the nv word spoils it, even if a stop follows later
        nv_arm <= 1'b0;
      else if (stop_ev && nv_pending)
      begin
        // nv cell is only written once the frame ends with a stop
        nv_pending <= 1'b0;
        mem_we <= nv_arm;
        mem_waddr <= nv_addr;
        mem_wdata <= nv_data;
      end
      else if (start_ev)
        nv_pending <= 1'b0;
    end
  end

  dcp_mem #(.DEPTH(NUM_LOC), .WIDTH(WORD_W), .AW(ADDR_W)) u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_addr_ptr),
    .rdata(mem_rdata)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  // per channel dac register and latched output
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        shadow[g] <= WORD_RESET;
        out_reg[g] <= WORD_RESET;
      end
      else if (clk_en)
      begin
        if (last_rx && commit && vol_ok && mem_addr_ptr == ADDR_W'(g))
          shadow[g] <= {data_hi, rx_byte};
        if (!lat_s[g])
          out_reg[g] <= shadow[g];
      end
    end
    assign dac_out[g*WORD_W +: WORD_W] = out_reg[g];
    chk_latch_hold: assert property (lat_s[g] |=> $stable(out_reg[g]))
      else $error("output register moved while latch high");
    chk_latch_pass: assert property (!lat_s[g] |=> out_reg[g] == $past(shadow[g]))
      else $error("output register missed shadow while latch low");
  end

  // helper copy of lock bits for the lock check
  logic [NUM_LOC-1:0] lock_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      lock_q <= '0;
    else if (clk_en)
      lock_q <= location_write_lock_bits;
  end

  sequence s_addr_end;
    last_rx && state == st_addr;
  endsequence
  sequence s_word_end;
    last_rx && state == st_wdata && byte_sel && vol_ok && mem_addr_ptr >= ADDR_W'(NCH);
  endsequence

  chk_hs_stop_leave: assert property (stop_ev |=> !hs_mode)
    else $error("hs mode survived stop");
  chk_hs_code_nack: assert property (s_addr_end ##0 rx_byte[7:3] == HS_CODE_TOP
    |=> hs_mode && !ack_go ##1 !sda_oe)
    else $error("hs master code acked or hs not entered");
  chk_start_abort: assert property (start_ev |=> state == st_addr && !sda_oe && bitcnt == 4'h0)
    else $error("start did not reset the interface");
  chk_ptr_kept: assert property ((start_ev || stop_ev) |=> $stable(mem_addr_ptr))
    else $error("pointer changed at start or stop");
  chk_gc_acked: assert property (s_addr_end ##0 rx_byte == GC_ADDR_BYTE
    |=> ack_go && pend == st_gc)
    else $error("general call address not acked");
  chk_nv_nack: assert property (last_rx && state == st_cmd && nv_pending
    |=> !ack_go && pend == st_ignore)
    else $error("byte after nv write without stop was acked");
  chk_lock_block: assert property (mem_we && mem_waddr <= VOL_LAST |-> !lock_q[mem_waddr])
    else $error("locked volatile location written");
  chk_commit_word: assert property (s_word_end |=> mem_we && mem_wdata[7:0] == $past(rx_byte))
    else $error("word not committed on final bit");
  chk_bad_cmd_nack: assert property (last_rx && state == st_cmd && cmd_code != CMD_WRITE
    && cmd_code != CMD_READ |=> !ack_go ##1 pend == st_ignore)
    else $error("invalid command acked");
endmodule // dcp_port

// [test_dcp_port.sv]
/*
  self-checking bench for the dac command port, driven by the i2c host model.
  assumes a 50 mhz core clock; bus timing comes from the host model.
*/
`timescale 1ns/100ps
module test_dcp_port
  import dcp_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda, sda_out, sda_oe, hs_mode, wake_pulse, gc_reset_pulse, ack;
  logic addr_select_pin_hi = 1'b0;
  logic addr_select_pin_lo = 1'b0;
  logic prog_voltage_present = 1'b0;
  logic [31:0] location_write_lock_bits = 32'h0;
  logic [7:0] channel_output_latch_pin_n = 8'hff;
  logic [127:0] dac_out;
  logic [4:0] mem_addr_ptr;
  logic [7:0] hb, lb;
  logic [7:0] bad_cmd [3] = '{8'h42, 8'h44, 8'h60};
  int n_mismatch = 0;
  int checked = 0;
  int n_wake = 0;
  int n_gcr = 0;
  localparam logic [6:0] DEV = {DEF_UPPER_ADDR, 2'b00};

  // 20 ns core clock
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  dcp_port #(.NCH(8), .NONVOLATILE(1'b0)) u_dcp_port (
    .core_clk, .rst_n, .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .addr_select_pin_hi, .addr_select_pin_lo, .upper_client_addr_bits(DEF_UPPER_ADDR),
    .prog_voltage_present, .location_write_lock_bits, .channel_output_latch_pin_n,
    .dac_out, .hs_mode, .mem_addr_ptr, .wake_pulse, .gc_reset_pulse);

  dcp_host_model u_dcp_host_model (.core_clk, .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));

  // strobes last one cycle, so they are tallied at every edge
  always @(posedge core_clk)
  begin
    if (wake_pulse === 1'b1)
      n_wake <= n_wake + 1;
    if (gc_reset_pulse === 1'b1)
      n_gcr <= n_gcr + 1;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic bs();
    u_dcp_host_model.start();
  endtask

  task automatic bp();
    u_dcp_host_model.stop();
  endtask

  // one byte out, then the acknowledge is compared
  task automatic sb(input logic [7:0] d, input logic exp_ack);
    u_dcp_host_model.byte_wr(d, ack);
    chk($sformatf("ack of %h", d), {15'h0, ack}, {15'h0, exp_ack});
  endtask

  task automatic wr(input logic [4:0] loc, input logic [15:0] v);
    bs();
    sb({DEV, 1'b0}, 1'b1);
    sb({loc, CMD_WRITE, 1'b0}, 1'b1);
    sb(v[15:8], 1'b1);
    sb(v[7:0], 1'b1);
    bp();
  endtask

  // last skips the command part and reuses the held pointer
  task automatic rd(input logic [4:0] loc, input logic last, input logic [15:0] exp);
    if (!last)
    begin
      bs();
      sb({DEV, 1'b0}, 1'b1);
      sb({loc, CMD_READ, 1'b0}, 1'b1);
    end
    bs();
    sb({DEV, 1'b1}, 1'b1);
    u_dcp_host_model.byte_rd(1'b1, hb);
    u_dcp_host_model.byte_rd(1'b0, lb);
    bp();
    chk($sformatf("word at %h", loc), {hb, lb}, exp);
  endtask

  // the latch path takes a few cycles through its synchroniser
  task automatic wait_dac(input int ch, input logic [15:0] exp);
    int n;
    n = 0;
    while (dac_out[ch*16+:16] !== exp && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    chk($sformatf("channel %0d", ch), dac_out[ch*16+:16], exp);
    if (n == 20)
      close_out();
  endtask

  // cut a hang short
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("pointer", {11'h0, mem_addr_ptr}, 16'h0);
    chk("hs mode", {15'h0, hs_mode}, 16'h0);
    chk("sda oe", {15'h0, sda_oe}, 16'h0);
    chk("sda out", {15'h0, sda_out}, 16'h0);
    wr(5'h08, 16'h1234);
    chk("pointer", {11'h0, mem_addr_ptr}, 16'h8);
    rd(5'h08, 1'b0, 16'h1234);
    rd(5'h00, 1'b1, 16'h1234);
    for (int p = 1; p < 4; p++)
    begin
      {addr_select_pin_hi, addr_select_pin_lo} <= p[1:0];
      bs();
      sb({DEF_UPPER_ADDR, p[1:0], 1'b0}, 1'b1);
      bp();
      bs();
      sb({DEV, 1'b0}, 1'b0);
      bp();
    end
    {addr_select_pin_hi, addr_select_pin_lo} <= 2'b00;
    // word cut one bit short of its end must vanish
    bs();
    sb({DEV, 1'b0}, 1'b1);
    sb({5'h09, CMD_WRITE, 1'b0}, 1'b1);
    sb(8'haa, 1'b1);
    // the stop's own scl rise clocks the seventh bit, so the eighth never comes
    for (int i = 0; i < 6; i++)
      u_dcp_host_model.put_bit(1'b1);
    bp();
    chk("pointer", {11'h0, mem_addr_ptr}, 16'h9);
    rd(5'h09, 1'b0, 16'h0000);
    location_write_lock_bits <= 32'h0000_0400;
    wr(5'h0a, 16'h5555);
    rd(5'h0a, 1'b0, 16'h0000);
    location_write_lock_bits <= 32'h0;
    // two channel words in one frame, held back until the latch pins drop
    bs();
    sb({DEV, 1'b0}, 1'b1);
    for (int c = 0; c < 2; c++)
    begin
      sb({c[4:0], CMD_WRITE, 1'b0}, 1'b1);
      sb(8'h0a, 1'b1);
      sb({4'hb, c[3:0]}, 1'b1);
    end
    bp();
    chk("channel 0 held", dac_out[15:0], 16'h0);
    channel_output_latch_pin_n <= 8'hfc;
    wait_dac(0, 16'h0ab0);
    wait_dac(1, 16'h0ab1);
    channel_output_latch_pin_n <= 8'hff;
    // bad code or unimplemented place: refused, then deaf until a start
    for (int k = 0; k < 3; k++)
    begin
      bs();
      sb({DEV, 1'b0}, 1'b1);
      sb(bad_cmd[k], 1'b0);
      sb(8'h12, 1'b0);
      bp();
    end
    bs();
    sb({HS_CODE_TOP, 3'h5}, 1'b0);
    chk("hs mode", {15'h0, hs_mode}, 16'h1);
    bs();
    sb({DEV, 1'b0}, 1'b1);
    bs();
    chk("hs mode", {15'h0, hs_mode}, 16'h1);
    sb({DEV, 1'b0}, 1'b1);
    bp();
    chk("hs mode", {15'h0, hs_mode}, 16'h0);
    for (int g = 0; g < 2; g++)
    begin
      bs();
      sb(GC_ADDR_BYTE, 1'b1);
      sb(g == 0 ? GC_WAKE_CODE : GC_RESET_CODE, 1'b1);
      bp();
    end
    chk("wake count", n_wake[15:0], 16'h1);
    chk("reset count", n_gcr[15:0], 16'h1);
    wr(NV_FIRST, 16'hbeef);
    rd(NV_FIRST, 1'b0, 16'h0000);
    prog_voltage_present <= 1'b1;
    wr(5'h11, 16'h4321);
    rd(5'h11, 1'b0, 16'h4321);
    bs();
    sb({DEV, 1'b0}, 1'b1);
    sb({5'h12, CMD_WRITE, 1'b0}, 1'b1);
    sb(8'h01, 1'b1);
    sb(8'h02, 1'b1);
    sb({5'h08, CMD_READ, 1'b0}, 1'b0);
    bp();
    rd(5'h12, 1'b0, 16'h0000);
    close_out();
  end
endmodule // test_dcp_port
